// ===== shared/aum_pkg.sv
// How it works
// - Bit 4 masks link protocol errors
// - Bit 5 masks surprise down errors
// - Bit 12 masks poisoned packets
// - Bit 13 masks flow control errors
// - Bit 16 masks unexpected completions
// - Bit 17 masks receiver overflow
// - Bit 18 masks malformed packets
// - Bit 19 masks end-to-end CRC errors
// - Bit 20 masks unsupported requests
// - Masked class neither logged nor reported
// - Bit 14 reads zero, ignores writes
// - Bit 15 reads zero, read-only
// - Bit 0 sticky writable, no effect
// - Status bit pairs with mask bit
package aum_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] STATUS_OFS = 12'h104;
    localparam logic [11:0] MASK_OFS = 12'h108;
    localparam logic [11:0] INT_MASK_OFS = 12'h180;
    localparam logic [11:0] INT_STAT_OFS = 12'h184;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int OBSOLETE_ERROR_BIT = 0;
    localparam int LINK_PROTOCOL_ERR_BIT = 4;
    localparam int SURPRISE_DOWN_ERR_BIT = 5;
    localparam int POISONED_BIT = 12;
    localparam int FLOW_CONTROL_ERR_BIT = 13;
    localparam int COMPLETION_TIMEOUT_BIT = 14;
    localparam int COMPLETER_ABORT_BIT = 15;
    localparam int UNEXPECTED_COMPLETION_BIT = 16;
    localparam int RECEIVER_OVERFLOW_BIT = 17;
    localparam int BAD_PACKET_FORMAT_BIT = 18;
    localparam int ECRC_BIT = 19;
    localparam int UNSUPPORTED_REQ_BIT = 20;
    // Writable mask bits; bit 0 stored but has no effect
    localparam logic [31:0] MASK_WR = 32'h001f_3031;
    // Bits that can log an event
    localparam logic [31:0] EVENT_BITS = 32'h001f_3030;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] INT_MASK_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [11:0] addr;
        logic write;
        logic [31:0] wdata;
    } aum_req_s;

    typedef enum logic [1:0] {
        AUM_IDLE,
        AUM_ACCESS
    } aum_phase_e;
endpackage

// ===== hdl/aum_sticky_reg.sv
`timescale 1ns/1ps
// Sticky register: only power-on reset clears it; write-one-clear optional
module aum_sticky_reg #(
    parameter logic [31:0] WR_BITS = 32'h0,
    parameter logic [31:0] RST_VAL = 32'h0,
    parameter bit W1C = 1'b0
) (
    // Clock and power-on reset
    input wire logic i_ref_clk,
    input wire logic i_por,
    // Update
    input wire logic i_we,
    input wire logic [31:0] i_wdata,
    input wire logic [31:0] i_set,
    // State
    output logic [31:0] o_value
);
    logic [31:0] next_value;

    // Set wins over a simultaneous clear
    assign next_value = W1C ? (((o_value & ~({32{i_we}} & i_wdata)) | i_set) & WR_BITS)
                            : ((i_we ? i_wdata : o_value) & WR_BITS);

    always_ff @(posedge i_ref_clk) begin
        if (i_por) begin
            o_value <= RST_VAL;
        end else begin
            o_value <= next_value;
        end
    end
endmodule

// ===== hdl/aum_mask_bank.sv
// Chosen here: the APB register port.
`timescale 1ns/1ps
module aum_mask_bank (
    // Clock and resets
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_hot_reset,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Error detection from the port
    input wire logic [31:0] i_err_detect,
    // Reporting
    output logic [31:0] o_err_report,
    output logic [31:0] o_mask,
    output logic o_irq
);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    aum_pkg::aum_req_s req;
    aum_pkg::aum_phase_e phase;
    aum_pkg::aum_phase_e next_phase;
    logic access;
    logic wr;
    logic hit_mask;
    logic hit_stat;
    logic hit_imask;
    logic hit_istat;
    logic mapped;
    logic [31:0] mask;
    logic [31:0] status;
    logic [31:0] int_mask;
    logic [31:0] int_stat;
    logic [31:0] logged;
    logic [31:0] rd_mux;
    logic [31:0] next_report;
    logic setup;
    logic next_pready;
    logic next_pslverr;
    logic [31:0] next_prdata;
    logic next_irq;

    // Word decode; the two low address bits are ignored
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        return a[11:2] == ofs[11:2];
    endfunction

    assign req = '{addr: i_paddr, write: i_pwrite, wdata: i_pwdata};
    // Answer at the first access cycle; zero wait states
    assign access = i_psel && i_penable && phase == aum_pkg::AUM_ACCESS;
    assign wr = access && req.write;
    assign hit_mask = hit(req.addr, aum_pkg::MASK_OFS);
    assign hit_stat = hit(req.addr, aum_pkg::STATUS_OFS);
    assign hit_imask = hit(req.addr, aum_pkg::INT_MASK_OFS);
    assign hit_istat = hit(req.addr, aum_pkg::INT_STAT_OFS);
    assign mapped = hit_mask || hit_stat || hit_imask || hit_istat;
    // Setup cycle: the answer is prepared here so it stands in access
    assign setup = i_psel && !i_penable;
    assign next_phase = setup ? aum_pkg::AUM_ACCESS : aum_pkg::AUM_IDLE;

    // ------------------------------------------------------------
    // Mask and status
    // ------------------------------------------------------------
    // writable mask bits only
    aum_sticky_reg #(
        .WR_BITS(aum_pkg::MASK_WR),
        .RST_VAL(aum_pkg::MASK_RESET),
        .W1C(1'b0)
    ) u_mask (
        .i_ref_clk(i_ref_clk),
        .i_por(i_reset),
        .i_we(wr && hit_mask),
        .i_wdata(req.wdata),
        .i_set(32'h0000_0000),
        .o_value(mask)
    );

    assign logged = i_err_detect & ~mask & aum_pkg::EVENT_BITS;

    aum_sticky_reg #(
        .WR_BITS(aum_pkg::EVENT_BITS),
        .RST_VAL(aum_pkg::STATUS_RESET),
        .W1C(1'b1)
    ) u_status (
        .i_ref_clk(i_ref_clk),
        .i_por(i_reset),
        .i_we(wr && hit_stat),
        .i_wdata(req.wdata),
        .i_set(logged),
        .o_value(status)
    );

    // Interrupt status mirrors logged events; hot reset clears it
    aum_sticky_reg #(
        .WR_BITS(aum_pkg::EVENT_BITS),
        .RST_VAL(aum_pkg::STATUS_RESET),
        .W1C(1'b1)
    ) u_istat (
        .i_ref_clk(i_ref_clk),
        .i_por(i_reset || i_hot_reset),
        .i_we(wr && hit_istat),
        .i_wdata(req.wdata),
        .i_set(logged),
        .o_value(int_stat)
    );

    aum_sticky_reg #(
        .WR_BITS(aum_pkg::EVENT_BITS),
        .RST_VAL(aum_pkg::INT_MASK_RESET),
        .W1C(1'b0)
    ) u_imask (
        .i_ref_clk(i_ref_clk),
        .i_por(i_reset || i_hot_reset),
        .i_we(wr && hit_imask),
        .i_wdata(req.wdata),
        .i_set(32'h0000_0000),
        .o_value(int_mask)
    );

    // ------------------------------------------------------------
    // Read mux and outputs
    // ------------------------------------------------------------
    // hardwired bits read zero
    assign rd_mux = hit_mask ? mask :
                    hit_stat ? status :
                    hit_imask ? int_mask :
                    hit_istat ? int_stat : 32'h0000_0000;
    assign next_report = logged;
    // Unmapped reads return zero with an error flag
    assign next_pready = setup;
    assign next_pslverr = setup && !mapped;
    assign next_prdata = (setup && !req.write) ? rd_mux : 32'h0000_0000;
    assign next_irq = |(int_stat & int_mask);

    // Bus phase
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            phase <= aum_pkg::AUM_IDLE;
        end else begin
            phase <= next_phase;
        end
    end

    // Bus answer, one cycle wide
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_prdata <= 32'h0000_0000;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_prdata <= next_prdata;
            o_pready <= next_pready;
            o_pslverr <= next_pslverr;
        end
    end

    // Reporting outputs
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_err_report <= 32'h0000_0000;
            o_mask <= 32'h0000_0000;
            o_irq <= 1'b0;
        end else begin
            o_err_report <= next_report;
            o_mask <= mask;
            o_irq <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    localparam int LINK = aum_pkg::LINK_PROTOCOL_ERR_BIT;
    masked_no_log_a: assert property (
        i_err_detect[LINK] && mask[LINK] |=> !status[LINK] || $past(status[LINK]))
        else $error("masked event was logged");

    unmasked_logs_a: assert property (
        i_err_detect[aum_pkg::POISONED_BIT] && !mask[aum_pkg::POISONED_BIT]
        |=> status[aum_pkg::POISONED_BIT] && o_err_report[aum_pkg::POISONED_BIT])
        else $error("unmasked event not logged");
    masked_no_report_a: assert property (
        mask[aum_pkg::SURPRISE_DOWN_ERR_BIT] |=> !o_err_report[aum_pkg::SURPRISE_DOWN_ERR_BIT])
        else $error("masked event reported");
    hard_zero_a: assert property (
        mask[aum_pkg::COMPLETION_TIMEOUT_BIT] == 1'b0 && mask[aum_pkg::COMPLETER_ABORT_BIT] == 1'b0)
        else $error("hardwired mask bit set");
    reserved_zero_a: assert property (
        (mask & ~aum_pkg::MASK_WR) == 32'h0000_0000)
        else $error("reserved mask bit set");
    mask_write_a: assert property (
        wr && hit_mask |=> mask == ($past(req.wdata) & aum_pkg::MASK_WR))
        else $error("mask write not stored");
    sticky_hold_a: assert property (
        i_hot_reset && !(wr && hit_mask) |=> $stable(mask))
        else $error("mask lost on hot reset");
    obsolete_bit_a: assert property (
        !o_err_report[aum_pkg::OBSOLETE_ERROR_BIT] && !status[aum_pkg::OBSOLETE_ERROR_BIT])
        else $error("obsolete bit had effect");
    pready_once_a: assert property (
        i_psel && !i_penable |=> o_pready ##1 !o_pready)
        else $error("pready timing wrong");

    // ------------------------------------------------------------
    // Output copies
    // ------------------------------------------------------------
    // Copies lag one edge, so each is held against the value before
    report_copy_a: assert property (
        !$past(i_reset) |-> o_err_report == $past(logged))
        else $error("report differs from logged events");
    mask_copy_a: assert property (
        !$past(i_reset) |-> o_mask == $past(mask))
        else $error("mask copy out of step");
    irq_level_a: assert property (
        !$past(i_reset) |-> o_irq == $past(next_irq))
        else $error("interrupt level wrong");

    // ------------------------------------------------------------
    // Bus checks
    // ------------------------------------------------------------
    mask_read_a: assert property (
        setup && !i_pwrite && hit_mask
        |=> o_prdata == $past(mask))
        else $error("mask read back wrong");
    status_read_a: assert property (
        setup && !i_pwrite && hit_stat
        |=> o_prdata == $past(status))
        else $error("status read back wrong");
    int_read_a: assert property (
        setup && !i_pwrite && hit_istat
        |=> o_prdata == $past(int_stat))
        else $error("interrupt status read back wrong");
    imask_read_a: assert property (
        setup && !i_pwrite && hit_imask
        |=> o_prdata == $past(int_mask))
        else $error("interrupt mask read back wrong");
    unmapped_refused_a: assert property (
        setup && !mapped
        |=> o_pslverr && o_prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (
        setup && mapped |=> !o_pslverr)
        else $error("mapped access refused");
    unmapped_write_a: assert property (
        wr && !mapped && !i_hot_reset
        |=> $stable(mask) && $stable(int_mask))
        else $error("unmapped write changed a register");
    idle_data_a: assert property (
        !o_pready |-> o_prdata == 32'h0000_0000 && !o_pslverr)
        else $error("bus answer outside access");

    // ------------------------------------------------------------
    // Hot reset
    // ------------------------------------------------------------
    hot_status_a: assert property (
        i_hot_reset && !(wr && hit_stat) && logged == 32'h0000_0000
        |=> $stable(status))
        else $error("status lost on hot reset");
    hot_clear_a: assert property (
        i_hot_reset
        |=> int_stat == 32'h0000_0000 && int_mask == 32'h0000_0000)
        else $error("interrupt state kept over hot reset");

    // ------------------------------------------------------------
    // Per-class checks
    // ------------------------------------------------------------
    // one check set per error class
    for (genvar g = 0; g < 32; g++) begin : g_class
        if (aum_pkg::EVENT_BITS[g]) begin : g_event
            class_masked_a: assert property (
                @(posedge i_ref_clk) disable iff (i_reset)
                i_err_detect[g] && mask[g] |=> !o_err_report[g])
                else $error("masked class reported");
            class_logged_a: assert property (
                @(posedge i_ref_clk) disable iff (i_reset)
                i_err_detect[g] && !mask[g] |=> status[g] && o_err_report[g])
                else $error("unmasked class not logged");
            class_write_a: assert property (
                @(posedge i_ref_clk) disable iff (i_reset)
                wr && hit_mask |=> mask[g] == $past(i_pwdata[g]))
                else $error("class mask bit not stored");
            class_clear_a: assert property (
                @(posedge i_ref_clk) disable iff (i_reset)
                wr && hit_stat && i_pwdata[g] && !logged[g] |=> !status[g])
                else $error("class status not cleared");
            class_hit_c: cover property (
                @(posedge i_ref_clk) i_err_detect[g] && !mask[g]);
        end else begin : g_fixed
            // Bit 0, bits 14-15 and reserved bits can never log or interrupt
            class_silent_a: assert property (
                @(posedge i_ref_clk) disable iff (i_reset)
                !status[g] && !o_err_report[g] && !int_stat[g] && !int_mask[g])
                else $error("fixed bit logged");
        end
    end

    report_c: cover property (i_err_detect[aum_pkg::ECRC_BIT] ##2 o_irq);
    masked_c: cover property (
        mask[aum_pkg::UNSUPPORTED_REQ_BIT] && i_err_detect[aum_pkg::UNSUPPORTED_REQ_BIT]);
    hot_keep_c: cover property (i_hot_reset && mask != 32'h0000_0000);
    clear_c: cover property (wr && hit_stat && |logged);
endmodule

// ===== testbench/aum_root_model.sv
`timescale 1ns/1ps
// Root side: takes every error message the port sends
module aum_root_model (
    // Clock
    input wire logic i_ref_clk,
    // Messages
    input wire logic [31:0] i_report,
    output logic [31:0] o_msg
);
    always_ff @(posedge i_ref_clk) begin
        o_msg <= i_report;
    end
endmodule

// ===== testbench/aer_uncorrectable_error_mask_bench.sv
`timescale 1ns/1ps
module aer_uncorrectable_error_mask_bench;
    logic clk, rst, hot, psel, pen, pwr, rdy, slv, irq, stb;
    logic [11:0] addr;
    logic [31:0] wd, rd, det, rep, msk, msg, m;
    logic [2:0] dv = 3'h0;
    int errors, checked, seed;
    logic [31:0] exp_q[$];
    logic [31:0] rep_q[$];
    logic [1:0] err_q[$];

    aum_mask_bank i_dut (.i_ref_clk(clk), .i_reset(rst), .i_hot_reset(hot),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr),
        .i_pwdata(wd), .o_prdata(rd), .o_pready(rdy), .o_pslverr(slv),
        .i_err_detect(det), .o_err_report(rep), .o_mask(msk), .o_irq(irq));
    aum_root_model i_root (.i_ref_clk(clk), .i_report(rep), .o_msg(msg));

    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end

    task automatic stop_test;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic bad(input string s);
        errors++;
        $display("MISMATCH %0t %s", $time, s);
    endtask

    // se holds the expected irq and slave error
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       input logic [31:0] e, input logic [1:0] se);
        int n;
        @(posedge clk);
        psel <= 1;
        pen <= 0;
        addr <= a;
        pwr <= w;
        wd <= d;
        exp_q.push_back(e);
        err_q.push_back(se);
        @(posedge clk);
        pen <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        if (n == 20) bad("no pready");
        psel <= 0;
        pen <= 0;
    endtask

    task automatic dt(input logic [31:0] d, input logic [31:0] mk);
        @(posedge clk);
        det <= d;
        stb <= 1;
        rep_q.push_back(d & ~mk & aum_pkg::EVENT_BITS);
        @(posedge clk);
        det <= 0;
        stb <= 0;
    endtask

    // ------------------------------------------------------------
    // Monitor
    // ------------------------------------------------------------
    always @(posedge clk) begin
        dv <= {dv[1:0], stb};
        if (psel && pen && rdy === 1'b1 && exp_q.size() > 0) begin
            checked++;
            if ({irq, slv} !== err_q.pop_front() || (!pwr && rd !== exp_q[0])) bad("apb");
            if (!pwr && addr == aum_pkg::MASK_OFS && msk !== exp_q[0]) bad("o_mask");
            void'(exp_q.pop_front());
        end
        if (dv[1] && rep_q.size() > 0) begin
            checked++;
            if (msg !== rep_q.pop_front()) bad("report");
        end
    end

    initial begin
        #200000;
        bad("timeout");
        stop_test;
    end

    initial begin
        seed = 32'hbe351d5f;
        rst = 1;
        hot = 0;
        psel = 0;
        pen = 0;
        pwr = 0;
        stb = 0;
        addr = 12'h0;
        wd = 32'h0;
        det = 32'h0;
        errors = 0;
        checked = 0;
        repeat (2) @(posedge clk);
        rst <= 0;
        apb(aum_pkg::MASK_OFS, 1'b0, 32'h0, 32'h0, 2'h0);
        apb(aum_pkg::INT_MASK_OFS, 1'b1, aum_pkg::EVENT_BITS, 32'h0, 2'h0);
        dt(32'h10, 32'h0);
        apb(aum_pkg::STATUS_OFS, 1'b0, 32'h0, 32'h10, 2'h2);
        apb(aum_pkg::INT_STAT_OFS, 1'b1, 32'h10, 32'h0, 2'h2);
        apb(aum_pkg::STATUS_OFS, 1'b1, 32'h10, 32'h0, 2'h0);
        apb(aum_pkg::STATUS_OFS, 1'b0, 32'h0, 32'h0, 2'h0);
        apb(aum_pkg::INT_MASK_OFS, 1'b1, 32'h0, 32'h0, 2'h0);
        dt(32'h20, 32'h0);
        apb(aum_pkg::INT_STAT_OFS, 1'b0, 32'h0, 32'h20, 2'h0);
        apb(aum_pkg::MASK_OFS, 1'b1, 32'hffffffff, 32'h0, 2'h0);
        apb(aum_pkg::MASK_OFS, 1'b0, 32'h0, aum_pkg::MASK_WR, 2'h0);
        dt(32'hffffffff, aum_pkg::MASK_WR);
        @(posedge clk);
        hot <= 1;
        @(posedge clk);
        hot <= 0;
        apb(aum_pkg::MASK_OFS, 1'b0, 32'h0, aum_pkg::MASK_WR, 2'h0);
        for (int b = 0; b < 32; b++) begin
            if (aum_pkg::EVENT_BITS[b]) begin
                apb(aum_pkg::MASK_OFS, 1'b1, 32'h1 << b, 32'h0, 2'h0);
                dt(aum_pkg::EVENT_BITS, 32'h1 << b);
            end
        end
        for (int i = 0; i < 10; i++) begin
            m = $random(seed);
            apb(aum_pkg::MASK_OFS, 1'b1, m, 32'h0, 2'h0);
            dt($random(seed), m & aum_pkg::MASK_WR);
        end
        apb(12'h200, 1'b1, 32'hffffffff, 32'h0, 2'h1);
        apb(12'h200, 1'b0, 32'h0, 32'h0, 2'h1);
        @(posedge clk);
        rst <= 1;
        @(posedge clk);
        rst <= 0;
        apb(aum_pkg::MASK_OFS, 1'b0, 32'h0, 32'h0, 2'h0);
        repeat (4) @(posedge clk);
        stop_test;
    end
endmodule
